//--- mie_pkg.sv
// Shared types and constants for the instruction execution subset
package mie_pkg;
  localparam int unsigned PC_W       = 11;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ADDR_W     = 7;
  localparam int unsigned STACK_D    = 4;
  localparam logic [3:0]  BCD_MAX    = 4'h9;
  localparam logic [3:0]  BCD_FIX    = 4'h6;
  localparam logic [7:0]  ONE_BYTE   = 8'h01;
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 11'h004;

  // Decoded operations presented by fetch
  typedef enum logic [4:0] {
    MIE_IDLE_OP,
    MIE_WD_PRECLEAR_FIRST,
    MIE_WD_PRECLEAR_SECOND,
    MIE_INVERT_MEMORY,
    MIE_INVERT_TO_WORKING,
    MIE_BCD_ADJUST,
    MIE_SUB_ONE_MEMORY,
    MIE_SUB_ONE_TO_WORKING,
    MIE_ADD_ONE_MEMORY,
    MIE_ADD_ONE_TO_WORKING,
    MIE_POWER_DOWN,
    MIE_BRANCH_ABSOLUTE,
    MIE_COPY_MEM_TO_WORKING,
    MIE_COPY_IMM_TO_WORKING,
    MIE_COPY_WORKING_TO_MEM,
    MIE_OR_MEM_TO_WORKING,
    MIE_OR_IMM_TO_WORKING,
    MIE_BITWISE_OR_TO_MEMORY,
    MIE_SUBROUTINE_EXIT,
    MIE_SUBROUTINE_EXIT_VALUE,
    MIE_INTERRUPT_EXIT,
    MIE_ROTATE_LEFT_MEMORY,
    MIE_ROTATE_LEFT_TO_WORKING,
    MIE_CALL
  } mie_op_e;

  typedef struct packed {
    mie_op_e             op;
    logic [ADDR_W-1:0]   mem_addr;
    logic [DATA_W-1:0]   imm;
    logic [PC_W-1:0]     target;
  } mie_instr_s;

  typedef struct packed {
    logic                 we;
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    wdata;
  } mie_mem_wr_s;

  typedef struct packed {
    logic zero;
    logic carry;
    logic half_carry;
    logic watchdog_timeout_flag;
    logic sleep_entered_flag;
  } mie_flags_s;
endpackage

//--- mie_stack.sv
// Return address stack built from flip-flops
`timescale 1ns/1ps
`default_nettype none
module mie_stack #(
  parameter int unsigned DEPTH = mie_pkg::STACK_D,
  parameter int unsigned WIDTH = mie_pkg::PC_W
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_push,
  input  wire logic             i_pop,
  input  wire logic [WIDTH-1:0] i_data,
  output logic      [WIDTH-1:0] o_top
);
  import mie_pkg::*;
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("stack depth must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    ptr_q;
  wire  [PW-1:0]    ptr_dec = ptr_q - PW'(1);

  // Wrapping pointer: overflow overwrites the oldest entry
  assign o_top = mem_q[ptr_dec];

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ptr_q <= '0;
    end else if (i_push) begin
      ptr_q <= ptr_q + PW'(1);
    end else if (i_pop) begin
      ptr_q <= ptr_dec;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_push) begin
      mem_q[ptr_q] <= i_data;
    end
  end
endmodule
`default_nettype wire

//--- mie_exec.sv
// Execution unit for a subset of the 8-bit core instruction set
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Pre-clears act only when alternated
// - Effective clear resets counter, timeout, sleep
// - Invert memory byte, zero flag only
// - Invert-to-working leaves memory, sets zero
// - Low nibble plus six if >9/half-carry
// - High nibble plus six, result to memory
// - BCD adjust touches only carry
// - Decrement byte or to working, zero flag
// - Increment byte or to working, zero flag
// - Power-down halts, keeps program counter and working register
// - Power-down clears watchdog, sets sleep flag
// - Branch loads target, two cycles, no flags
// - Copies move data, no flags
// - Idle op changes nothing but the program counter
// - OR into working updates zero
// - OR to memory writes back, zero
// - Return pops program counter, no flags
// - Return-with-value loads immediate too
// - Interrupt return sets global enable, clears it if an interrupt is pending
// - Rotate left, bit seven wraps, no flags
// - Program counter writes take two cycles
module mie_exec #(
  parameter int unsigned WD_W = 16
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_resetn,
  input  wire logic                        i_instr_valid,
  input  wire mie_pkg::mie_instr_s         i_instr,
  input  wire logic [mie_pkg::DATA_W-1:0]  i_mem_rdata,
  input  wire logic                        i_irq_pending,
  input  wire logic                        i_wake,
  input  wire logic                        i_watchdog_overflow,
  output logic                             o_instr_ready,
  output logic [mie_pkg::ADDR_W-1:0]       o_mem_raddr,
  output mie_pkg::mie_mem_wr_s             o_mem_wr,
  output logic [mie_pkg::PC_W-1:0]         o_pc,
  output logic [mie_pkg::DATA_W-1:0]       o_working_register,
  output mie_pkg::mie_flags_s              o_flags,
  output logic                             o_global_irq_enable,
  output logic [WD_W-1:0]                  o_watchdog_counter,
  output logic                             o_clock_stopped
);
  import mie_pkg::*;

  initial begin
    if (WD_W < 2) begin
      $error("watchdog counter width too small");
    end
  end

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return v == ZERO_BYTE;
  endfunction

  function automatic logic nib_fix(input logic [3:0] n, input logic f);
    return (n > BCD_MAX) || f;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_RUN, ST_DUMMY, ST_SLEEP} mie_state_e;

  mie_state_e        state_q, state_d;
  logic [PC_W-1:0]   pc_q, pc_d;
  logic [DATA_W-1:0] acc_q, acc_d;
  mie_flags_s        flg_q, flg_d;
  logic              gie_q, gie_d;
  logic [WD_W-1:0]   wd_q, wd_d;
  logic              last_pre_q, last_pre_d;
  logic              pre_seen_q, pre_seen_d;
  mie_mem_wr_s       wr_q, wr_d;
  logic              wake_meta_q, wake_sync_q;

  // ---------------------------------------------------------------
  // Decode and datapath
  // ---------------------------------------------------------------
  wire               take    = i_instr_valid && (state_q == ST_RUN);
  wire mie_op_e      op      = i_instr.op;
  wire [DATA_W-1:0]  m       = i_mem_rdata;
  wire [DATA_W-1:0]  inv_v   = ~m;
  wire [DATA_W-1:0]  dec_v   = m - ONE_BYTE;
  wire [DATA_W-1:0]  inc_v   = m + ONE_BYTE;
  wire [DATA_W-1:0]  rol_v   = {m[DATA_W-2:0], m[DATA_W-1]};
  wire [DATA_W-1:0]  orm_v   = acc_q | m;
  wire [DATA_W-1:0]  ori_v   = acc_q | i_instr.imm;
  wire               fix_lo  = nib_fix(acc_q[3:0], flg_q.half_carry);
  wire [4:0]         lo_sum  = {1'b0, acc_q[3:0]} + (fix_lo ? {1'b0, BCD_FIX} : 5'h00);
  wire [3:0]         hi_in   = acc_q[7:4] + {3'h0, lo_sum[4]};
  wire               fix_hi  = nib_fix(hi_in, flg_q.carry) || (lo_sum[4] && acc_q[7:4] == 4'hF);
  wire [4:0]         hi_sum  = {1'b0, hi_in} + (fix_hi ? {1'b0, BCD_FIX} : 5'h00);
  wire [DATA_W-1:0]  bcd_v   = {hi_sum[3:0], lo_sum[3:0]};
  wire               bcd_c   = hi_sum[4] || flg_q.carry || (lo_sum[4] && acc_q[7:4] == 4'hF);
  wire               is_pre1 = (op == MIE_WD_PRECLEAR_FIRST);
  wire               is_pre2 = (op == MIE_WD_PRECLEAR_SECOND);
  wire               pre_hit = take && (is_pre1 || is_pre2) && pre_seen_q && (last_pre_q != is_pre2);
  wire               two_cyc = (op == MIE_BRANCH_ABSOLUTE) || (op == MIE_SUBROUTINE_EXIT) ||
                               (op == MIE_SUBROUTINE_EXIT_VALUE) || (op == MIE_INTERRUPT_EXIT) ||
                               (op == MIE_CALL);
  wire               ret_op  = take && ((op == MIE_SUBROUTINE_EXIT) || (op == MIE_SUBROUTINE_EXIT_VALUE) ||
                               (op == MIE_INTERRUPT_EXIT));
  wire               irq_go  = take && (op == MIE_INTERRUPT_EXIT) && i_irq_pending;
  wire               push    = (take && op == MIE_CALL) || irq_go;
  wire [PC_W-1:0]    stk_top;
  wire [PC_W-1:0]    push_v  = irq_go ? stk_top : pc_q + PC_W'(1);

  mie_stack #(
    .DEPTH (STACK_D),
    .WIDTH (PC_W)
  ) u_stack (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_push   (push && !irq_go),
    .i_pop    (ret_op && !irq_go),
    .i_data   (push_v),
    .o_top    (stk_top)
  );

  always_comb begin
    state_d    = state_q;
    pc_d       = pc_q;
    acc_d      = acc_q;
    flg_d      = flg_q;
    gie_d      = gie_q;
    wd_d       = i_watchdog_overflow ? '0 : wd_q + WD_W'(1);
    last_pre_d = last_pre_q;
    pre_seen_d = pre_seen_q;
    wr_d       = '0;
    unique case (state_q)
      ST_DUMMY: begin
        state_d = ST_RUN;
      end
      ST_SLEEP: begin
        wd_d = wd_q;
        if (wake_sync_q) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (take) begin
          pc_d = pc_q + PC_W'(1);
          if (two_cyc) begin
            state_d = ST_DUMMY;
          end
          unique case (op)
            MIE_IDLE_OP: begin
            end
            MIE_WD_PRECLEAR_FIRST, MIE_WD_PRECLEAR_SECOND: begin
              last_pre_d = is_pre2;
              pre_seen_d = 1'b1;
              if (pre_hit) begin
                wd_d = '0;
                flg_d.watchdog_timeout_flag = 1'b0;
                flg_d.sleep_entered_flag = 1'b0;
                pre_seen_d = 1'b0;
              end
            end
            MIE_INVERT_MEMORY: begin
              wr_d = '{1'b1, i_instr.mem_addr, inv_v};
              flg_d.zero = is_zero(inv_v);
            end
            MIE_INVERT_TO_WORKING: begin
              acc_d = inv_v;
              flg_d.zero = is_zero(inv_v);
            end
            MIE_BCD_ADJUST: begin
              wr_d = '{1'b1, i_instr.mem_addr, bcd_v};
              flg_d.carry = bcd_c;
            end
            MIE_SUB_ONE_MEMORY: begin
              wr_d = '{1'b1, i_instr.mem_addr, dec_v};
              flg_d.zero = is_zero(dec_v);
            end
            MIE_SUB_ONE_TO_WORKING: begin
              acc_d = dec_v;
              flg_d.zero = is_zero(dec_v);
            end
            MIE_ADD_ONE_MEMORY: begin
              wr_d = '{1'b1, i_instr.mem_addr, inc_v};
              flg_d.zero = is_zero(inc_v);
            end
            MIE_ADD_ONE_TO_WORKING: begin
              acc_d = inc_v;
              flg_d.zero = is_zero(inc_v);
            end
            MIE_POWER_DOWN: begin
              state_d = ST_SLEEP;
              wd_d = '0;
              flg_d.sleep_entered_flag = 1'b1;
              flg_d.watchdog_timeout_flag = 1'b0;
            end
            MIE_BRANCH_ABSOLUTE, MIE_CALL: begin
              pc_d = i_instr.target;
            end
            MIE_COPY_MEM_TO_WORKING: begin
              acc_d = m;
            end
            MIE_COPY_IMM_TO_WORKING: begin
              acc_d = i_instr.imm;
            end
            MIE_COPY_WORKING_TO_MEM: begin
              wr_d = '{1'b1, i_instr.mem_addr, acc_q};
            end
            MIE_OR_MEM_TO_WORKING: begin
              acc_d = orm_v;
              flg_d.zero = is_zero(orm_v);
            end
            MIE_OR_IMM_TO_WORKING: begin
              acc_d = ori_v;
              flg_d.zero = is_zero(ori_v);
            end
            MIE_BITWISE_OR_TO_MEMORY: begin
              wr_d = '{1'b1, i_instr.mem_addr, orm_v};
              flg_d.zero = is_zero(orm_v);
            end
            MIE_SUBROUTINE_EXIT: begin
              pc_d = stk_top;
            end
            MIE_SUBROUTINE_EXIT_VALUE: begin
              pc_d = stk_top;
              acc_d = i_instr.imm;
            end
            MIE_INTERRUPT_EXIT: begin
              // Pending service runs first; return address stays stacked
              pc_d = irq_go ? IRQ_VECTOR : stk_top;
              gie_d = !irq_go;
            end
            MIE_ROTATE_LEFT_MEMORY: begin
              wr_d = '{1'b1, i_instr.mem_addr, rol_v};
            end
            MIE_ROTATE_LEFT_TO_WORKING: begin
              acc_d = rol_v;
            end
            default: begin
            end
          endcase
        end
      end
    endcase
    // Timeout wins over any clear in the same cycle
    if (i_watchdog_overflow) begin
      flg_d.watchdog_timeout_flag = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_q    <= ST_RUN;
      pc_q       <= PC_RESET;
      acc_q      <= ZERO_BYTE;
      flg_q      <= '0;
      gie_q      <= 1'b0;
      wd_q       <= '0;
      last_pre_q <= 1'b0;
      pre_seen_q <= 1'b0;
      wr_q       <= '0;
    end else begin
      state_q    <= state_d;
      pc_q       <= pc_d;
      acc_q      <= acc_d;
      flg_q      <= flg_d;
      gie_q      <= gie_d;
      wd_q       <= wd_d;
      last_pre_q <= last_pre_d;
      pre_seen_q <= pre_seen_d;
      wr_q       <= wr_d;
    end
  end

  // ---------------------------------------------------------------
  // Wake synchroniser
  // ---------------------------------------------------------------
  // Wake comes from pins, outside the core clock
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wake_meta_q <= 1'b0;
      wake_sync_q <= 1'b0;
    end else begin
      wake_meta_q <= i_wake;
      wake_sync_q <= wake_meta_q;
    end
  end

  assign o_instr_ready       = (state_q == ST_RUN);
  assign o_mem_raddr         = i_instr.mem_addr;
  assign o_mem_wr            = wr_q;
  assign o_pc                = pc_q;
  assign o_working_register  = acc_q;
  assign o_flags             = flg_q;
  assign o_global_irq_enable = gie_q;
  assign o_watchdog_counter  = wd_q;
  assign o_clock_stopped     = (state_q == ST_SLEEP);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_branch;
    take && op == MIE_BRANCH_ABSOLUTE;
  endsequence

  sequence s_return;
    take && op == MIE_SUBROUTINE_EXIT;
  endsequence

  pre_repeat_a: assert property (take && is_pre1 && !(pre_seen_q && last_pre_q)
    && !i_watchdog_overflow |=> wd_q != '0 || $past(wd_q) == '1)
    else $error("repeated preclear changed watchdog");
  wd_clear_a: assert property (pre_hit && !i_watchdog_overflow |=> wd_q == '0
    && !flg_q.watchdog_timeout_flag && !flg_q.sleep_entered_flag) else $error("watchdog clear incomplete");
  invert_mem_a: assert property (take && op == MIE_INVERT_MEMORY |=> wr_q.we
    && wr_q.wdata == ~$past(m) && flg_q.carry == $past(flg_q.carry)) else $error("invert memory wrong");
  invert_acc_a: assert property (take && op == MIE_INVERT_TO_WORKING
    |=> !wr_q.we && acc_q == ~$past(m)) else $error("invert to working wrong");
  bcd_flags_a: assert property (take && op == MIE_BCD_ADJUST
    |=> flg_q.zero == $past(flg_q.zero) && acc_q == $past(acc_q)) else $error("bcd adjust touched other state");
  dec_acc_a: assert property (take && op == MIE_SUB_ONE_TO_WORKING
    |=> acc_q == $past(m) - ONE_BYTE && flg_q.zero == (acc_q == ZERO_BYTE)) else $error("decrement wrong");
  inc_mem_a: assert property (take && op == MIE_ADD_ONE_MEMORY
    |=> wr_q.wdata == $past(m) + ONE_BYTE) else $error("increment wrong");
  sleep_entry_a: assert property (take && op == MIE_POWER_DOWN && !i_watchdog_overflow
    |=> o_clock_stopped && flg_q.sleep_entered_flag && wd_q == '0) else $error("power down entry wrong");
  branch_two_a: assert property (s_branch
    |=> !o_instr_ready ##1 o_instr_ready && pc_q == $past(pc_q)) else $error("branch not two cycles");
  or_mem_a: assert property (take && op == MIE_BITWISE_OR_TO_MEMORY
    |=> wr_q.wdata == ($past(acc_q) | $past(m))) else $error("or to memory wrong");
  interrupt_exit_gie_a: assert property (take && op == MIE_INTERRUPT_EXIT && !i_irq_pending
    |=> gie_q) else $error("interrupt return left enable clear");
  rotate_a: assert property (take && op == MIE_ROTATE_LEFT_TO_WORKING
    |=> acc_q == {$past(m[6:0]), $past(m[7])}) else $error("rotate wrong");
  copy_flags_a: assert property (take && !i_watchdog_overflow && (op == MIE_COPY_MEM_TO_WORKING
    || op == MIE_COPY_IMM_TO_WORKING || op == MIE_COPY_WORKING_TO_MEM) |=> flg_q == $past(flg_q))
    else $error("copy changed flags");
  idle_hold_a: assert property (take && op == MIE_IDLE_OP
    |=> acc_q == $past(acc_q) && !wr_q.we && flg_q.zero == $past(flg_q.zero) && flg_q.carry == $past(flg_q.carry))
    else $error("idle op changed state");
  ret_pc_a: assert property (s_return
    |=> pc_q == $past(stk_top) && !o_instr_ready) else $error("return address wrong");
  sleep_hold_a: assert property (o_clock_stopped && !wake_sync_q
    |=> pc_q == $past(pc_q) && acc_q == $past(acc_q)) else $error("power down lost state");
endmodule
`default_nettype wire

//--- mie_dmem_model.sv
// Data memory model standing behind the execution unit
`timescale 1ns/1ps
`default_nettype none
module mie_dmem_model (
  input  wire logic                       i_clk,
  input  wire logic [mie_pkg::ADDR_W-1:0] i_raddr,
  input  wire mie_pkg::mie_mem_wr_s       i_wr,
  output logic      [mie_pkg::DATA_W-1:0] o_rdata
);
  import mie_pkg::*;
  logic [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];

  // ----------------------------------------
  // Storage, arbitrary power-up contents
  // ----------------------------------------
  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) mem_q[i] = 8'(i) ^ 8'hC3;
  end
  assign o_rdata = mem_q[i_raddr];
  always @(posedge i_clk) begin
    if (i_wr.we) mem_q[i_wr.addr] <= i_wr.wdata;
  end
endmodule
`default_nettype wire

//--- tb_mcu_instruction_exec_subset.sv
// Self-checking testbench for the instruction execution subset
`timescale 1ns/1ps
`default_nettype none
module tb_mcu_instruction_exec_subset;
  import mie_pkg::*;
  localparam int unsigned WD_W    = 16;
  localparam int          MAX_CYC = 6000;
  logic                i_clk, i_resetn, instr_valid, irq_pending, wake, wd_overflow;
  mie_instr_s          instr;
  logic [DATA_W-1:0]   mem_rdata, o_working_register;
  logic [ADDR_W-1:0]   o_mem_raddr;
  mie_mem_wr_s         o_mem_wr;
  logic [PC_W-1:0]     o_pc, p;
  mie_flags_s          o_flags, f;
  logic                o_instr_ready, o_global_irq_enable, o_clock_stopped;
  logic [WD_W-1:0]     o_watchdog_counter;
  int                  miscompares, n_compared, cycles;

  mie_exec #(.WD_W(WD_W)) dut_u (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_instr_valid(instr_valid), .i_instr(instr),
    .i_mem_rdata(mem_rdata), .i_irq_pending(irq_pending), .i_wake(wake),
    .i_watchdog_overflow(wd_overflow), .o_instr_ready(o_instr_ready), .o_mem_raddr(o_mem_raddr),
    .o_mem_wr(o_mem_wr), .o_pc(o_pc), .o_working_register(o_working_register), .o_flags(o_flags),
    .o_global_irq_enable(o_global_irq_enable), .o_watchdog_counter(o_watchdog_counter),
    .o_clock_stopped(o_clock_stopped));
  mie_dmem_model mem_u (.i_clk(i_clk), .i_raddr(o_mem_raddr), .i_wr(o_mem_wr), .o_rdata(mem_rdata));

  // ----------------------------------------
  // Common tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Returns at the falling edge after the taking edge
  task automatic issue(input mie_op_e op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x,
                       input logic [PC_W-1:0] t);
    @(posedge i_clk);
    instr_valid <= 1'b1;
    instr       <= '{op, a, x, t};
    @(negedge i_clk);
    for (int n = 0; n < 50 && o_instr_ready !== 1'b1; n++) @(negedge i_clk);
    @(posedge i_clk);
    instr_valid <= 1'b0;
    @(negedge i_clk);
  endtask
  task automatic load(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    issue(MIE_COPY_IMM_TO_WORKING, 7'h00, v, 11'h000);
    issue(MIE_COPY_WORKING_TO_MEM, a, 8'h00, 11'h000);
  endtask
  task automatic op_m(input mie_op_e op, input logic [ADDR_W-1:0] a);
    issue(op, a, 8'h00, 11'h000);
  endtask
  task automatic overflow_pulse();
    @(posedge i_clk);
    wd_overflow <= 1'b1;
    @(posedge i_clk);
    wd_overflow <= 1'b0;
    @(negedge i_clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_copy_or();
    f = o_flags;
    issue(MIE_COPY_IMM_TO_WORKING, 7'h00, 8'h5A, 11'h000);
    chk(o_working_register, 8'h5A);
    chk(o_instr_ready, 1'b1);
    op_m(MIE_COPY_WORKING_TO_MEM, 7'h10);
    chk({o_mem_wr.we, o_mem_wr.addr, o_mem_wr.wdata}, {1'b1, 7'h10, 8'h5A});
    chk(o_flags, f);
    issue(MIE_OR_IMM_TO_WORKING, 7'h00, 8'h81, 11'h000);
    chk({o_working_register, o_flags.zero}, {8'hDB, 1'b0});
    issue(MIE_COPY_IMM_TO_WORKING, 7'h00, 8'h24, 11'h000);
    op_m(MIE_BITWISE_OR_TO_MEMORY, 7'h10);
    chk({o_mem_wr.we, o_mem_wr.addr, o_mem_wr.wdata}, {1'b1, 7'h10, 8'h7E});
    chk({o_working_register, o_flags.zero}, {8'h24, 1'b0});
    op_m(MIE_COPY_MEM_TO_WORKING, 7'h10);
    chk(o_working_register, 8'h7E);
    load(7'h11, 8'h00);
    op_m(MIE_OR_MEM_TO_WORKING, 7'h11);
    chk({o_working_register, o_flags.zero}, {8'h00, 1'b1});
  endtask
  task automatic t_invert_incdec();
    load(7'h20, 8'hFF);
    op_m(MIE_INVERT_MEMORY, 7'h20);
    chk({o_mem_wr.we, o_mem_wr.wdata, o_flags.zero}, {1'b1, 8'h00, 1'b1});
    op_m(MIE_INVERT_TO_WORKING, 7'h20);
    chk({o_mem_wr.we, o_working_register, o_flags.zero}, {1'b0, 8'hFF, 1'b0});
    op_m(MIE_ADD_ONE_TO_WORKING, 7'h20);
    chk({o_mem_wr.we, o_working_register, o_flags.zero}, {1'b0, 8'h01, 1'b0});
    load(7'h21, 8'hFF);
    op_m(MIE_ADD_ONE_MEMORY, 7'h21);
    chk({o_mem_wr.we, o_mem_wr.wdata, o_flags.zero}, {1'b1, 8'h00, 1'b1});
    op_m(MIE_SUB_ONE_MEMORY, 7'h21);
    chk({o_mem_wr.we, o_mem_wr.wdata, o_flags.zero}, {1'b1, 8'hFF, 1'b0});
    load(7'h22, 8'h01);
    op_m(MIE_SUB_ONE_TO_WORKING, 7'h22);
    chk({o_mem_wr.we, o_working_register, o_flags.zero}, {1'b0, 8'h00, 1'b1});
  endtask
  task automatic t_bcd_rotate();
    issue(MIE_COPY_IMM_TO_WORKING, 7'h00, 8'h3F, 11'h000);
    f = o_flags;
    op_m(MIE_BCD_ADJUST, 7'h30);
    chk({o_mem_wr.we, o_mem_wr.wdata, o_flags.carry}, {1'b1, 8'h45, 1'b0});
    issue(MIE_COPY_IMM_TO_WORKING, 7'h00, 8'h9A, 11'h000);
    op_m(MIE_BCD_ADJUST, 7'h30);
    chk({o_mem_wr.wdata, o_flags.carry}, {8'h00, 1'b1});
    chk({o_flags.zero, o_flags.half_carry}, {f.zero, f.half_carry});
    issue(MIE_COPY_IMM_TO_WORKING, 7'h00, 8'h12, 11'h000);
    op_m(MIE_BCD_ADJUST, 7'h30);
    chk({o_mem_wr.wdata, o_flags.carry}, {8'h72, 1'b1});
    load(7'h31, 8'h81);
    f = o_flags;
    op_m(MIE_ROTATE_LEFT_MEMORY, 7'h31);
    chk({o_mem_wr.we, o_mem_wr.wdata}, {1'b1, 8'h03});
    op_m(MIE_ROTATE_LEFT_TO_WORKING, 7'h31);
    chk({o_mem_wr.we, o_working_register}, {1'b0, 8'h06});
    chk(o_flags, f);
  endtask
  task automatic t_flow();
    f = o_flags;
    issue(MIE_BRANCH_ABSOLUTE, 7'h00, 8'h00, 11'h123);
    chk({o_pc, o_instr_ready}, {11'h123, 1'b0});
    @(negedge i_clk);
    chk(o_instr_ready, 1'b1);
    chk(o_flags, f);
    op_m(MIE_IDLE_OP, 7'h00);
    chk({o_pc, o_working_register}, {11'h124, 8'h06});
    chk(o_flags, f);
    p = o_pc;
    issue(MIE_CALL, 7'h00, 8'h00, 11'h200);
    op_m(MIE_SUBROUTINE_EXIT, 7'h00);
    chk({o_pc, o_instr_ready}, {p + 11'h001, 1'b0});
    chk(o_flags, f);
    issue(MIE_CALL, 7'h00, 8'h00, 11'h300);
    // Each call sits one address further on, so it stacks one more
    issue(MIE_SUBROUTINE_EXIT_VALUE, 7'h00, 8'h77, 11'h000);
    chk({o_pc, o_working_register}, {p + 11'h002, 8'h77});
    issue(MIE_CALL, 7'h00, 8'h00, 11'h400);
    @(posedge i_clk);
    irq_pending <= 1'b1;
    op_m(MIE_INTERRUPT_EXIT, 7'h00);
    chk({o_pc, o_global_irq_enable}, {IRQ_VECTOR, 1'b0});
    @(posedge i_clk);
    irq_pending <= 1'b0;
    op_m(MIE_INTERRUPT_EXIT, 7'h00);
    chk({o_pc, o_global_irq_enable}, {p + 11'h003, 1'b1});
  endtask
  task automatic t_watchdog();
    overflow_pulse();
    chk(o_flags.watchdog_timeout_flag, 1'b1);
    op_m(MIE_WD_PRECLEAR_FIRST, 7'h00);
    op_m(MIE_WD_PRECLEAR_FIRST, 7'h00);
    chk(o_flags.watchdog_timeout_flag, 1'b1);
    op_m(MIE_WD_PRECLEAR_SECOND, 7'h00);
    chk({o_watchdog_counter, o_flags.watchdog_timeout_flag, o_flags.sleep_entered_flag}, 18'h0);
    overflow_pulse();
    op_m(MIE_WD_PRECLEAR_SECOND, 7'h00);
    op_m(MIE_WD_PRECLEAR_SECOND, 7'h00);
    chk(o_flags.watchdog_timeout_flag, 1'b1);
  endtask
  task automatic t_sleep();
    issue(MIE_COPY_IMM_TO_WORKING, 7'h00, 8'hA7, 11'h000);
    op_m(MIE_POWER_DOWN, 7'h00);
    p = o_pc;
    chk({o_clock_stopped, o_flags.sleep_entered_flag, o_flags.watchdog_timeout_flag}, 3'b110);
    chk(o_watchdog_counter, 16'h0000);
    repeat (6) @(negedge i_clk);
    chk({o_instr_ready, o_watchdog_counter}, 17'h0);
    chk({o_pc, o_working_register}, {p, 8'hA7});
    @(posedge i_clk);
    wake <= 1'b1;
    @(posedge i_clk);
    wake <= 1'b0;
    for (int n = 0; n < 20 && o_clock_stopped !== 1'b0; n++) @(negedge i_clk);
    chk(o_clock_stopped, 1'b0);
    op_m(MIE_WD_PRECLEAR_FIRST, 7'h00);
    op_m(MIE_WD_PRECLEAR_SECOND, 7'h00);
    chk(o_flags.sleep_entered_flag, 1'b0);
  endtask

  // ----------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == MAX_CYC) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    i_resetn = 1'b0; instr_valid = 1'b0; irq_pending = 1'b0; wake = 1'b0; wd_overflow = 1'b0;
    instr = '{MIE_IDLE_OP, 7'h00, 8'h00, 11'h000};
    miscompares = 0; n_compared = 0; cycles = 0;
    repeat (4) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(negedge i_clk);
    chk({o_pc, o_working_register, o_global_irq_enable, o_instr_ready}, {PC_RESET, 8'h00, 2'b01});
    chk({o_flags, o_watchdog_counter}, 21'h0);
    t_copy_or();
    t_invert_incdec();
    t_bcd_rotate();
    t_flow();
    t_watchdog();
    t_sleep();
    report_and_stop();
  end
endmodule
`default_nettype wire
